// ---- shared/swd_defs.svh ----
// Offsets, field positions, reset values and timing of the watchdog block
`ifndef SWD_DEFS_SVH
`define SWD_DEFS_SVH
`define SWD_OFS_PERIOD 8'h14
`define SWD_OFS_KICK 8'h15
`define SWD_OFS_QACFG 8'h2D
`define SWD_OFS_REPLY 8'h2E
`define SWD_OFS_CHAL 8'h2F
`define SWD_PER_MSB 7
`define SWD_PER_LSB 5
`define SWD_TALLY_MSB 4
`define SWD_TALLY_LSB 1
`define SWD_FLAG_BIT 6
`define SWD_TALLY_RST 4'h1
`define SWD_TALLY_MAX 4'hF
`define SWD_SEED_RST 4'h5
`define SWD_KICK_BYTE 8'hFF
`define SWD_CHAL_FIRST 4'hC
`define SWD_RTALLY_FULL 2'h3
`define SWD_TAPS_0 4'hC
`define SWD_TAPS_1 4'h9
`define SWD_TAPS_2 4'hC
`define SWD_TAPS_3 4'h9
`define SWD_TICK_US 1000
`define SWD_CLK_MHZ 20
`define SWD_TICK_CYC (`SWD_TICK_US * `SWD_CLK_MHZ)
`endif

// ---- shared/swd_pkg.sv ----
// Types shared by the watchdog block
package swd_pkg;
    typedef enum logic [1:0] {
        SWD_AUTO = 2'h0,
        SWD_TIMEOUT = 2'h1,
        SWD_WINDOW = 2'h2,
        SWD_QA = 2'h3
    } swd_style_type;
    typedef enum logic [1:0] {
        SWD_IDLE = 2'h0,
        SWD_CLOSED = 2'h1,
        SWD_OPEN = 2'h3
    } swd_state_type;
endpackage : swd_pkg

// ---- logic/swd_timer.sv ----
// Period timer: tick prescaler, half-period and expiry pulses
`timescale 1ns/1ps
`include "swd_defs.svh"
module swd_timer #(
    parameter int TICK_CYCLES = `SWD_TICK_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Control
    input wire logic run,
    input wire logic restart,
    input wire logic [5:0] period_ticks,
    // Events
    output logic half_ff,
    output logic expire_ff
);
    // Refuse a divider too short to count
    if (TICK_CYCLES < 2) begin : g_tick_chk
        $error("TICK_CYCLES too small");
    end
    logic [31:0] sub_ff, nxt_sub;
    logic [5:0] tick_ff, nxt_tick;
    logic nxt_half, nxt_expire;
    logic tick_done;

    // Next count: sub-tick divider then whole ticks
    always_comb begin
        tick_done = (sub_ff == 32'(TICK_CYCLES - 1));
        nxt_sub = tick_done ? 32'h0000_0000 : sub_ff + 32'h0000_0001;
        nxt_tick = tick_done ? tick_ff + 6'h01 : tick_ff;
        nxt_half = tick_done && (nxt_tick == {1'b0, period_ticks[5:1]});
        nxt_expire = tick_done && (nxt_tick == period_ticks);
        if (nxt_expire) begin
            nxt_tick = 6'h00;
        end
        if (!run || restart) begin
            nxt_sub = 32'h0000_0000;
            nxt_tick = 6'h00;
            nxt_half = 1'b0;
            nxt_expire = 1'b0;
        end
    end

    // Register the counter
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sub_ff <= 32'h0000_0000;
            tick_ff <= 6'h00;
            half_ff <= 1'b0;
            expire_ff <= 1'b0;
        end else begin
            sub_ff <= nxt_sub;
            tick_ff <= nxt_tick;
            half_ff <= nxt_half;
            expire_ff <= nxt_expire;
        end
    end

    chk_restart_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        restart |=> !expire_ff) else $error("expiry right after restart");
endmodule : swd_timer

// ---- logic/swd_lfsr.sv ----
// Question generator: 4-bit shift register with selectable taps
`timescale 1ns/1ps
`include "swd_defs.svh"
module swd_lfsr (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Control
    input wire logic load,
    input wire logic step,
    input wire logic [3:0] seed,
    input wire logic [1:0] polynomial_select,
    // State
    output logic [3:0] value_ff
);
    logic [3:0] nxt_value;
    logic [3:0] taps;
    logic fb;

    // Seed while load is high, else shift on step
    always_comb begin
        unique case (polynomial_select)
            2'h0: taps = `SWD_TAPS_0;
            2'h1: taps = `SWD_TAPS_1;
            2'h2: taps = `SWD_TAPS_2;
            2'h3: taps = `SWD_TAPS_3;
        endcase
        fb = ^(value_ff & taps) | (value_ff == 4'h0);
        nxt_value = value_ff;
        if (load) begin
            nxt_value = seed;
        end else if (step) begin
            nxt_value = {value_ff[2:0], fb};
        end
    end

    // Register the generator
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            value_ff <= `SWD_SEED_RST;
        end else begin
            value_ff <= nxt_value;
        end
    end

    chk_seed_load: assert property (@(posedge sys_clk) disable iff (rst)
        load |=> value_ff == $past(seed)) else $error("seed not loaded");
endmodule : swd_lfsr

// ---- logic/swd_top.sv ----
// Watchdog supervisor with period, kick and question-and-answer registers
`timescale 1ns/1ps
`include "swd_defs.svh"
module swd_top #(
    parameter int TICK_CYCLES = `SWD_TICK_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register access from the serial port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Settings held in the companion configuration register
    input wire swd_pkg::swd_style_type supervision_style,
    input wire logic [1:0] period_scaler,
    input wire logic [1:0] fault_threshold_select,
    input wire logic supervisor_on,
    // Events
    output logic supervisor_event_flag,
    output logic watchdog_fire
);
    import swd_pkg::*;

    // Refuse a divider too short to count
    if (TICK_CYCLES < 2) begin : g_tick_chk
        $error("TICK_CYCLES too small");
    end

    // Register state
    logic [2:0] period_select_ff, nxt_period_select;
    logic [3:0] fault_tally_ff, nxt_fault_tally;
    logic [1:0] reply_gen_ff, nxt_reply_gen;
    logic [1:0] poly_sel_ff, nxt_poly_sel;
    logic [3:0] seed_rd_ff, nxt_seed_rd;
    logic [3:0] seed_eff_ff, nxt_seed_eff;
    logic [7:0] reply_byte_ff, nxt_reply_byte;
    logic reply_fault_flag_ff, nxt_reply_fault_flag;
    logic [1:0] reply_tally_ff, nxt_reply_tally;
    logic first_q_ff, nxt_first_q;
    swd_state_type state_ff, nxt_state;
    logic [7:0] nxt_rdata;
    logic nxt_event, nxt_fire;

    // Decoded accesses and internal events
    logic wr_period, wr_kick, wr_qacfg, wr_reply, wr_chal;
    logic kick, answer, answer_ok, err_evt, restart, advance;
    logic half, expire;
    logic [3:0] lfsr_value, challenge_value;
    logic [7:0] expected;
    logic [5:0] period_ticks;
    logic [3:0] thr;

    // Address decode of writes
    always_comb begin
        wr_period = reg_wr && (reg_addr == `SWD_OFS_PERIOD);
        wr_kick = reg_wr && (reg_addr == `SWD_OFS_KICK);
        wr_qacfg = reg_wr && (reg_addr == `SWD_OFS_QACFG);
        wr_reply = reg_wr && (reg_addr == `SWD_OFS_REPLY);
        wr_chal = reg_wr && (reg_addr == `SWD_OFS_CHAL);
    end

    // Period length in ticks: (period + 1) * (scaler + 1)
    always_comb begin
        period_ticks = 6'({3'h0, period_select_ff} + 6'h01)
            * 6'({4'h0, period_scaler} + 6'h01);
    end

    // Expected reply from question, reply tally and generation setting
    always_comb begin
        challenge_value = first_q_ff ? `SWD_CHAL_FIRST : lfsr_value;
        expected = {challenge_value ^ {reply_tally_ff, reply_tally_ff},
            ~challenge_value} ^ {reply_gen_ff, 6'h00};
    end

    // Service detection and error classification
    always_comb begin
        kick = wr_kick && (reg_wdata == `SWD_KICK_BYTE) && supervisor_on
            && (supervision_style != SWD_QA);
        answer = wr_reply && supervisor_on && (state_ff != SWD_IDLE)
            && (supervision_style == SWD_QA);
        answer_ok = answer && (reg_wdata == expected);
        advance = answer_ok && (reply_tally_ff == 2'h0);
        err_evt = 1'b0;
        if (state_ff != SWD_IDLE && supervision_style != SWD_AUTO) begin
            err_evt = expire
                || (kick && state_ff == SWD_CLOSED)
                || (answer && !answer_ok);
        end
        restart = kick || advance || expire;
    end

    // Supervision state: idle, closed half, open half
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            SWD_IDLE: begin
                if (supervisor_on) begin
                    nxt_state = (supervision_style == SWD_WINDOW)
                        ? SWD_CLOSED : SWD_OPEN;
                end
            end
            SWD_CLOSED: begin
                if (half) begin
                    nxt_state = SWD_OPEN;
                end
            end
            SWD_OPEN: begin
                if (restart && supervision_style == SWD_WINDOW) begin
                    nxt_state = SWD_CLOSED;
                end
            end
            default: nxt_state = SWD_IDLE;
        endcase
        if (!supervisor_on) begin
            nxt_state = SWD_IDLE;
        end
    end

    // Threshold for the fire output
    always_comb begin
        unique case (fault_threshold_select)
            2'h0: thr = 4'h0;
            2'h1: thr = 4'h5;
            2'h2: thr = 4'h9;
            2'h3: thr = 4'hF;
        endcase
    end

    // Next values of the register fields, hidden seed and event outputs
    always_comb begin
        nxt_period_select = period_select_ff;
        nxt_fault_tally = fault_tally_ff;
        nxt_reply_gen = reply_gen_ff;
        nxt_poly_sel = poly_sel_ff;
        nxt_seed_rd = seed_rd_ff;
        nxt_seed_eff = seed_eff_ff;
        nxt_reply_byte = reply_byte_ff;
        nxt_reply_fault_flag = reply_fault_flag_ff;
        nxt_reply_tally = reply_tally_ff;
        nxt_first_q = first_q_ff;
        if (wr_period) begin
            nxt_period_select = reg_wdata[`SWD_PER_MSB:`SWD_PER_LSB];
        end
        if (wr_qacfg) begin
            nxt_reply_gen = reg_wdata[7:6];
            nxt_poly_sel = reg_wdata[5:4];
            nxt_seed_rd = reg_wdata[3:0];
            nxt_seed_eff = reg_wdata[3:0];
        end
        if (wr_reply) begin
            nxt_reply_byte = reg_wdata;
        end
        // Clear by writing one; a new wrong answer wins
        if (wr_chal && reg_wdata[`SWD_FLAG_BIT]) begin
            nxt_reply_fault_flag = 1'b0;
        end
        if (answer && !answer_ok) begin
            nxt_reply_fault_flag = 1'b1;
        end
        if (err_evt && fault_tally_ff != `SWD_TALLY_MAX) begin
            nxt_fault_tally = fault_tally_ff + 4'h1;
        end
        if (state_ff == SWD_IDLE) begin
            nxt_reply_tally = supervisor_on ? `SWD_RTALLY_FULL : 2'h0;
            nxt_first_q = supervisor_on;
        end else if (advance) begin
            nxt_reply_tally = `SWD_RTALLY_FULL;
            nxt_first_q = 1'b0;
        end else if (answer_ok) begin
            nxt_reply_tally = reply_tally_ff - 2'h1;
        end
        nxt_event = err_evt;
        nxt_fire = err_evt && (nxt_fault_tally >= thr);
    end

    // Read data, registered; unmapped and reserved bits read zero
    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                `SWD_OFS_PERIOD: nxt_rdata = {period_select_ff,
                    fault_tally_ff, 1'b0};
                `SWD_OFS_QACFG: nxt_rdata = {reply_gen_ff, poly_sel_ff,
                    seed_rd_ff};
                `SWD_OFS_REPLY: nxt_rdata = reply_byte_ff;
                `SWD_OFS_CHAL: nxt_rdata = {1'b0, reply_fault_flag_ff,
                    reply_tally_ff, (state_ff == SWD_IDLE) ? 4'h0
                    : challenge_value};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    // Register everything
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            period_select_ff <= 3'h0;
            fault_tally_ff <= `SWD_TALLY_RST;
            reply_gen_ff <= 2'h0;
            poly_sel_ff <= 2'h0;
            seed_rd_ff <= 4'h0;
            seed_eff_ff <= `SWD_SEED_RST;
            reply_byte_ff <= 8'h00;
            reply_fault_flag_ff <= 1'b0;
            reply_tally_ff <= 2'h0;
            first_q_ff <= 1'b0;
            state_ff <= SWD_IDLE;
            reg_rdata <= 8'h00;
            supervisor_event_flag <= 1'b0;
            watchdog_fire <= 1'b0;
        end else begin
            period_select_ff <= nxt_period_select;
            fault_tally_ff <= nxt_fault_tally;
            reply_gen_ff <= nxt_reply_gen;
            poly_sel_ff <= nxt_poly_sel;
            seed_rd_ff <= nxt_seed_rd;
            seed_eff_ff <= nxt_seed_eff;
            reply_byte_ff <= nxt_reply_byte;
            reply_fault_flag_ff <= nxt_reply_fault_flag;
            reply_tally_ff <= nxt_reply_tally;
            first_q_ff <= nxt_first_q;
            state_ff <= nxt_state;
            reg_rdata <= nxt_rdata;
            supervisor_event_flag <= nxt_event;
            watchdog_fire <= nxt_fire;
        end
    end

    // Period timer
    swd_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .run(state_ff != SWD_IDLE),
        .restart(restart),
        .period_ticks(period_ticks),
        .half_ff(half),
        .expire_ff(expire)
    );

    // Question generator, seeded while idle
    swd_lfsr u_lfsr (
        .sys_clk(sys_clk),
        .rst(rst),
        .load(state_ff == SWD_IDLE),
        .step(advance),
        .seed(seed_eff_ff),
        .polynomial_select(poly_sel_ff),
        .value_ff(lfsr_value)
    );

    // Checks
    sequence s_legal_kick;
        kick && state_ff == SWD_OPEN && !expire;
    endsequence
    sequence s_quiet;
        !supervisor_event_flag;
    endsequence

    chk_kick_legal: assert property (@(posedge sys_clk) disable iff (rst)
        s_legal_kick |=> s_quiet) else $error("legal kick made error");
    chk_tally_step: assert property (@(posedge sys_clk) disable iff (rst)
        err_evt && fault_tally_ff < 4'hF |=>
        fault_tally_ff == $past(fault_tally_ff) + 4'h1)
        else $error("tally did not count");
    chk_tally_reset: assert property (@(posedge sys_clk)
        rst |=> fault_tally_ff == 4'h1 && seed_eff_ff == 4'h5
        && seed_rd_ff == 4'h0) else $error("bad reset values");
    chk_wrong_flag: assert property (@(posedge sys_clk) disable iff (rst)
        answer && !answer_ok |=> reply_fault_flag_ff && supervisor_event_flag)
        else $error("wrong answer not flagged");
    chk_seed_match: assert property (@(posedge sys_clk) disable iff (rst)
        wr_qacfg |=> seed_rd_ff == seed_eff_ff)
        else $error("seed readback differs");
    chk_enable_show: assert property (@(posedge sys_clk) disable iff (rst)
        state_ff == SWD_IDLE && supervisor_on |=>
        reply_tally_ff == 2'h3 && challenge_value == 4'hC)
        else $error("enable values wrong");
    chk_off_idle: assert property (@(posedge sys_clk) disable iff (rst)
        !supervisor_on |=> state_ff == SWD_IDLE)
        else $error("runs while disabled");
    chk_event_each: assert property (@(posedge sys_clk) disable iff (rst)
        err_evt |=> supervisor_event_flag)
        else $error("event flag missed");
    chk_fire_now: assert property (@(posedge sys_clk) disable iff (rst)
        err_evt && fault_threshold_select == 2'h0 |=> watchdog_fire)
        else $error("immediate fire missed");
    chk_rsvd_zero: assert property (@(posedge sys_clk) disable iff (rst)
        reg_rd && reg_addr == `SWD_OFS_PERIOD |=> reg_rdata[0] == 1'b0)
        else $error("reserved bit not zero");
endmodule : swd_top

// ---- test/swd_host.sv ----
// Host model that reaches the watchdog registers and services it
`timescale 1ns/1ps
`include "swd_defs.svh"
module swd_host (
    // Clock
    input wire logic sys_clk,
    // Register port
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    // Idle lines at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Strobes drop low; address and data carry the inverse of their last value, not a stale copy
    task automatic release_bus();
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask : release_bus

    // One write strobe held across exactly one rising edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        release_bus();
    endtask : wr_reg

    // Read data stands in the cycle after the strobe edge
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        d = reg_rdata;
        release_bus();
    endtask : rd_reg

    // Service with the fixed all-ones byte
    task automatic kick();
        wr_reg(`SWD_OFS_KICK, `SWD_KICK_BYTE);
    endtask : kick

    // Reply is always sent as one whole byte
    task automatic answer(input logic [7:0] d);
        wr_reg(`SWD_OFS_REPLY, d);
    endtask : answer
endmodule : swd_host

// ---- test/test_swd_top.sv ----
// Testbench for the watchdog block: registers, kicks, errors, Q and A
`timescale 1ns/1ps
`include "swd_defs.svh"
module test_swd_top;
    import swd_pkg::*;
    localparam int TICKS = 4;
    localparam int LIMIT = 20000;
    typedef struct {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
        logic [7:0] exp;
    } swd_row_type;
    logic sys_clk;
    logic rst;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
    logic reg_wr, reg_rd, supervisor_on, supervisor_event_flag, watchdog_fire;
    swd_style_type supervision_style;
    logic [1:0] period_scaler, fault_threshold_select;
    logic [3:0] tally_m;
    int bad_count, tests_run, cycles, ev_count, n;
    swd_row_type rows [12];

    swd_top #(.TICK_CYCLES(TICKS)) swd_top_i (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .supervision_style(supervision_style),
        .period_scaler(period_scaler),
        .fault_threshold_select(fault_threshold_select),
        .supervisor_on(supervisor_on),
        .supervisor_event_flag(supervisor_event_flag),
        .watchdog_fire(watchdog_fire));
    swd_host swd_host_i (
        .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    // 20 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    task automatic cmp8(input logic [7:0] g, input logic [7:0] e, string m);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : cmp8

    task automatic cmp1(input logic g, input logic e, string m);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %0t %s got %b exp %b", $time, m, g, e);
        end
    endtask : cmp1

    // Tally value at which the fire output starts to pulse
    function automatic logic [3:0] thr(input logic [1:0] s);
        case (s)
            2'h0: return 4'h0;
            2'h1: return 4'h5;
            2'h2: return 4'h9;
            default: return 4'hF;
        endcase
    endfunction : thr

    // Hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            bad_count++;
            conclude();
        end
    end

    // Error monitor: own tally model, fire judged against the threshold
    always @(negedge sys_clk) begin
        if (rst) begin
            tally_m = `SWD_TALLY_RST;
        end else begin
            if (supervisor_event_flag === 1'b1) begin
                ev_count++;
                if (tally_m != `SWD_TALLY_MAX) tally_m = tally_m + 4'h1;
            end
            cmp1(watchdog_fire, (supervisor_event_flag === 1'b1)
                && (tally_m >= thr(fault_threshold_select)),
                "fire");
        end
    end

    task automatic set_cfg(swd_style_type s, logic [1:0] p, logic [1:0] t,
                           logic on);
        @(negedge sys_clk);
        supervision_style = s;
        period_scaler = p;
        fault_threshold_select = t;
        supervisor_on = on;
    endtask : set_cfg

    task automatic do_reset();
        @(negedge sys_clk);
        rst = 1'b1;
        supervisor_on = 1'b0;
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
    endtask : do_reset

    // Bounded wait for the event count to reach a target
    task automatic wait_ev(input int tgt, input int lim);
        for (int i = 0; i < lim && ev_count < tgt; i++) @(negedge sys_clk);
        cmp1(ev_count >= tgt, 1'b1, "event wait");
    endtask : wait_ev

    // No event may appear for a stretch of cycles
    task automatic quiet();
        repeat (2) @(negedge sys_clk);
        n = ev_count;
        repeat (150) @(negedge sys_clk);
        cmp1(ev_count == n, 1'b1, "quiet");
    endtask : quiet

    // Main sequence
    initial begin
        rst = 1'b1;
        supervision_style = SWD_TIMEOUT;
        period_scaler = 2'h0;
        fault_threshold_select = 2'h0;
        supervisor_on = 1'b0;
        bad_count = 0;
        tests_run = 0;
        cycles = 0;
        ev_count = 0;
        rows = '{'{0, 8'h14, 8'h00, 8'h02}, '{0, 8'h2D, 8'h00, 8'h00},
                 '{0, 8'h2E, 8'h00, 8'h00}, '{0, 8'h2F, 8'h00, 8'h00},
                 '{0, 8'h40, 8'h00, 8'h00}, '{1, 8'h14, 8'hFF, 8'hE2},
                 '{1, 8'h14, 8'h00, 8'h02}, '{1, 8'h2D, 8'hA5, 8'hA5},
                 '{1, 8'h2D, 8'h00, 8'h00}, '{1, 8'h2E, 8'h3C, 8'h3C},
                 '{1, 8'h2F, 8'hFF, 8'h00}, '{1, 8'h40, 8'hFF, 8'h00}};
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wr) swd_host_i.wr_reg(rows[i].addr, rows[i].data);
            swd_host_i.rd_reg(rows[i].addr, rd);
            cmp8(rd, rows[i].exp, "row");
        end
        // Every threshold setting, run into saturation by missed periods
        for (int t = 0; t < 4; t++) begin
            do_reset();
            set_cfg(SWD_TIMEOUT, 2'h0, 2'(t), 1'b1);
            wait_ev(ev_count + 16, 400);
            swd_host_i.rd_reg(`SWD_OFS_PERIOD, rd);
            cmp8(rd, 8'h1E, "saturated");
        end
        set_cfg(SWD_TIMEOUT, 2'h0, 2'h0, 1'b0);
        quiet();
        set_cfg(SWD_AUTO, 2'h0, 2'h0, 1'b1);
        quiet();
        // Long period kept alive by kicks, then lost to wrong bytes
        do_reset();
        swd_host_i.wr_reg(`SWD_OFS_PERIOD, 8'hE0);
        set_cfg(SWD_TIMEOUT, 2'h3, 2'h1, 1'b1);
        n = ev_count;
        repeat (8) begin
            repeat (40) @(negedge sys_clk);
            swd_host_i.kick();
        end
        cmp1(ev_count == n, 1'b1, "kicked");
        repeat (2) swd_host_i.wr_reg(`SWD_OFS_KICK, 8'h7F);
        wait_ev(n + 1, 200);
        swd_host_i.rd_reg(`SWD_OFS_PERIOD, rd);
        cmp8(rd, 8'hE4, "one error");
        // Kick inside the closed half of a window
        do_reset();
        swd_host_i.wr_reg(`SWD_OFS_PERIOD, 8'hE0);
        set_cfg(SWD_WINDOW, 2'h3, 2'h1, 1'b1);
        n = ev_count;
        swd_host_i.kick();
        wait_ev(n + 1, 10);
        // Question and answer on the hidden seed left by reset
        do_reset();
        swd_host_i.wr_reg(`SWD_OFS_PERIOD, 8'hE0);
        set_cfg(SWD_QA, 2'h3, 2'h1, 1'b1);
        swd_host_i.rd_reg(`SWD_OFS_CHAL, rd);
        cmp8(rd, 8'h3C, "first question");
        swd_host_i.answer(8'h33);
        swd_host_i.rd_reg(`SWD_OFS_REPLY, rd);
        cmp8(rd, 8'h33, "reply readback");
        swd_host_i.rd_reg(`SWD_OFS_CHAL, rd);
        cmp8(rd, 8'h2C, "reply counted");
        // Rest of the round; the last answer steps the generator from 5
        swd_host_i.answer(8'h63);
        swd_host_i.answer(8'h93);
        swd_host_i.answer(8'hC3);
        swd_host_i.rd_reg(`SWD_OFS_CHAL, rd);
        cmp8(rd, 8'h3B, "next question");
        n = ev_count;
        swd_host_i.answer(8'h00);
        wait_ev(n + 1, 5);
        swd_host_i.rd_reg(`SWD_OFS_CHAL, rd);
        cmp8(rd & 8'hC0, 8'h40, "flag set");
        swd_host_i.wr_reg(`SWD_OFS_CHAL, 8'h40);
        swd_host_i.rd_reg(`SWD_OFS_CHAL, rd);
        cmp8(rd & 8'hC0, 8'h00, "flag cleared");
        // Generation setting flips the top bits of the expected reply
        swd_host_i.wr_reg(`SWD_OFS_QACFG, 8'h40);
        swd_host_i.answer(8'h04);
        swd_host_i.rd_reg(`SWD_OFS_CHAL, rd);
        cmp8(rd, 8'h2B, "generation setting");
        conclude();
    end
endmodule : test_swd_top
